// [inc/asi_map.svh]
`ifndef ASI_MAP_SVH
`define ASI_MAP_SVH

// timing figures in their own units, oscillator rate in kHz
`define ASI_OSC_KHZ 20000
`define ASI_PH1_TIME_US 800
`define ASI_PH2_TIME_MS 3
`define ASI_PH2_HPF_TIME_MS 200

// spi frame length in rising clock edges
`define ASI_FRAME_EDGES 16

// offset monitor limit in percent of full scale
`define ASI_OFS_PCT 10

// linear result range
`define ASI_LIN_MAX 508
`define ASI_LIN_MIN -509

// special result codes (10-bit two's complement)
`define ASI_CODE_OVERRANGE 10'h1fd
`define ASI_CODE_OVERFLOW 10'h1fe
`define ASI_CODE_UNDERRANGE 10'h202
`define ASI_CODE_UNDERFLOW 10'h201
`define ASI_CODE_RESET 10'h000

// device status field positions
`define ASI_STAT_RESET_SEEN 0
`define ASI_STAT_INIT_PEND 1
`define ASI_STAT_OFS_ERR 2
`define ASI_STAT_SPI_FAULT 3

`endif

// [inc/asi_pkg.sv]
package asi_pkg;

  // init sequence, gray coded along the path
  typedef enum logic [1:0] {
    ASI_ST_RESET = 2'h0,
    ASI_ST_PH1 = 2'h1,
    ASI_ST_PH2 = 2'h3,
    ASI_ST_DONE = 2'h2
  } asi_state_type;

  // kind of answer to an acceleration request
  typedef enum logic [1:0] {
    ASI_RESP_DATA = 2'h0,
    ASI_RESP_RESET = 2'h1,
    ASI_RESP_NO_DATA = 2'h2,
    ASI_RESP_ERROR = 2'h3
  } asi_resp_type;

  typedef logic signed [9:0] asi_code_type;

endpackage

// [inc/asi_link_if.sv]
`timescale 1ns/10ps
interface asi_link_if;
  logic sclk;
  logic cs_act;
  logic enable;
  logic frame_end;
  logic fault;

  modport mon (input sclk, input cs_act, input enable, output frame_end, output fault);
  modport top (output sclk, output cs_act, output enable, input frame_end, input fault);
endinterface

// [hw/asi_frame_mon.sv]
`timescale 1ns/10ps
`include "asi_map.svh"
module asi_frame_mon #(
  parameter int EDGES = `ASI_FRAME_EDGES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  asi_link_if.mon lk
);
  import asi_pkg::*;

  localparam logic [5:0] EDGES_W = 6'(EDGES);

  logic sclk_prev_q;
  logic cs_prev_q;
  logic armed_q;
  logic early_q;
  logic [5:0] edge_cnt_q;
  logic frame_end_q;
  logic fault_q;

  wire cs_rise = lk.cs_act & ~cs_prev_q;
  wire cs_fall = ~lk.cs_act & cs_prev_q;
  wire sclk_rise = lk.sclk & ~sclk_prev_q;

  // edge history of the already synchronised pins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      sclk_prev_q <= lk.sclk;
      cs_prev_q <= lk.cs_act;
    end
  end

  // frames that start while disabled are ignored whole
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      armed_q <= 1'b0;
      early_q <= 1'b0;
      edge_cnt_q <= 6'h00;
    end else if (clk_en_i) begin
      if (cs_rise) begin
        armed_q <= lk.enable;
        early_q <= lk.sclk;
        edge_cnt_q <= 6'h00;
      end else if (lk.cs_act && sclk_rise && edge_cnt_q != 6'h3f) begin
        edge_cnt_q <= edge_cnt_q + 6'h01; // saturates, long frames still fault
      end
      if (cs_fall) begin
        armed_q <= 1'b0;
      end
    end
  end

  // end of frame pulse with its fault verdict
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      frame_end_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (clk_en_i) begin
      frame_end_q <= cs_fall & armed_q;
      fault_q <= cs_fall & armed_q & ((edge_cnt_q != EDGES_W) | early_q | lk.sclk);
    end
  end

  assign lk.frame_end = frame_end_q;
  assign lk.fault = fault_q;
endmodule

// [hw/asi_status_init.sv]
`timescale 1ns/10ps
`include "asi_map.svh"
// What this block does
// - offset monitor at or above tenth of full scale with enable sets offset error
// - first acceleration request after any reset answers with device-reset status
// - clock fault when rising edges in frame differ from 16 or clock high at select
// - each acceleration result is a 10-bit two's complement value
// - linear results limited to -509 through +508
// - 509 overrange, 510 overflow, -510 underrange, -511 underflow; 511, -512 never sent
// - filter output at or above sinc maximum reports overflow and clips the signal
// - after overflow, normal results resume a few samples after input returns
// - freeze input high stops copying results to output buffers, processing runs on
// - reads while frozen return results latest when the freeze went high
// - normal operating mode is entered by default at power on
// - internal reset held until all three rails are good, then init starts
// - phase one copies fuses into mirror registers, then powers fuses off
// - phase two also initialises high-pass filter when high-pass select is set
// - all spi transfers are ignored during phase one
// - phase two serves register frames; acceleration requests after the first get no-data
// - phase one lasts about 800 us
// - phase two lasts about 3 ms, or 200 ms with high-pass select
// - init pending flag set from reset until phase two finishes
// - clear-error clears transient flag; persisting condition sets it again
// - reset-seen set at reset release, cleared only by clear-error after init
// - each external error such as a clock fault is reported once, or twice when the faulty frame is an acceleration request
// - any detected error replaces acceleration data with an error indicator
module asi_status_init #(
  parameter int OSC_KHZ = `ASI_OSC_KHZ,
  parameter int PH1_CYCLES = (`ASI_PH1_TIME_US * `ASI_OSC_KHZ + 999) / 1000,
  parameter int PH2_CYCLES = `ASI_PH2_TIME_MS * `ASI_OSC_KHZ,
  parameter int PH2_HPF_CYCLES = `ASI_PH2_HPF_TIME_MS * `ASI_OSC_KHZ,
  parameter int LPF_W = 16,
  parameter int SINC_MAX = 1023,
  parameter int MON_W = 10,
  parameter int FULL_SCALE = 1023,
  parameter int RECOVER_SAMPLES = 3,
  parameter int FUSE_WORDS = 8,
  parameter int FUSE_DW = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [2:0] supply_ok_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic capture_freeze_input_i,
  input wire logic acc_request_i,
  input wire logic clear_error_i,
  input wire logic offset_monitor_enable_i,
  input wire logic [MON_W-1:0] offset_monitor_i,
  input wire logic highpass_select_i,
  input wire logic lpf_valid_i,
  input wire logic [2*LPF_W-1:0] lpf_data_i,
  input wire logic [FUSE_DW-1:0] fuse_data_i,
  input wire logic [$clog2(FUSE_WORDS)-1:0] mirror_addr_i,
  output logic [$clog2(FUSE_WORDS)-1:0] fuse_addr_o,
  output logic fuse_power_o,
  output logic [FUSE_DW-1:0] mirror_data_o,
  output logic int_reset_o,
  output logic normal_mode_o,
  output logic hpf_init_o,
  output logic spi_ignore_o,
  output logic reg_frame_o,
  output logic resp_valid_o,
  output asi_pkg::asi_resp_type resp_kind_o,
  output asi_pkg::asi_code_type acc_x_o,
  output asi_pkg::asi_code_type acc_y_o,
  output logic [7:0] device_status_reg_o,
  output logic init_pending_flag_o,
  output logic reset_seen_flag_o
);
  import asi_pkg::*;

  localparam int FAW = $clog2(FUSE_WORDS);
  localparam logic [FAW:0] FUSE_LAST = (FAW + 1)'(FUSE_WORDS);
  localparam logic [22:0] PH1_LAST = 23'(PH1_CYCLES - 1);
  localparam logic [22:0] PH2_LAST = 23'(PH2_CYCLES - 1);
  localparam logic [22:0] PH2_HPF_LAST = 23'(PH2_HPF_CYCLES - 1);
  localparam logic [MON_W-1:0] OFS_LIMIT = MON_W'((FULL_SCALE * `ASI_OFS_PCT + 99) / 100);
  localparam logic signed [LPF_W-1:0] SAT_HI = LPF_W'(SINC_MAX);
  localparam logic signed [LPF_W-1:0] SAT_LO = LPF_W'(-SINC_MAX);
  localparam logic signed [LPF_W-1:0] LIN_HI = LPF_W'(`ASI_LIN_MAX);
  localparam logic signed [LPF_W-1:0] LIN_LO = LPF_W'(`ASI_LIN_MIN);
  localparam logic [3:0] REC_LOAD = 4'(RECOVER_SAMPLES);

  // two-flop synchronisers for the rail, freeze, select and clock pins
  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;
  wire [5:0] pins = {supply_ok_i, capture_freeze_input_i, cs_n_i, sclk_i};

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_meta_q <= 6'h02;
      pin_sync_q <= 6'h02;
    end else if (clk_en_i) begin
      pin_meta_q <= pins;
      pin_sync_q <= pin_meta_q;
    end
  end

  wire rails_good = &pin_sync_q[5:3];
  wire freeze = pin_sync_q[2];

  // internal reset follows the rail monitors, a dip re-enters it
  logic int_rst_q;
  logic int_rst_prev_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      int_rst_q <= 1'b1;
      int_rst_prev_q <= 1'b1;
    end else if (clk_en_i) begin
      int_rst_q <= ~rails_good;
      int_rst_prev_q <= int_rst_q;
    end
  end

  wire rst_release = int_rst_prev_q & ~int_rst_q;

  // factory mode is never entered
  logic normal_mode_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      normal_mode_q <= 1'b1;
    end else if (clk_en_i) begin
      normal_mode_q <= 1'b1;
    end
  end

  // init sequencer with its phase timer
  asi_state_type state_q;
  logic [22:0] phase_cnt_q;
  logic hpf_sel_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q <= ASI_ST_RESET;
      phase_cnt_q <= 23'h000000;
      hpf_sel_q <= 1'b0;
    end else if (clk_en_i) begin
      if (int_rst_q) begin
        state_q <= ASI_ST_RESET;
        phase_cnt_q <= 23'h000000;
      end else begin
        case (state_q)
          ASI_ST_RESET: begin
            state_q <= ASI_ST_PH1;
            phase_cnt_q <= 23'h000000;
          end
          ASI_ST_PH1: begin
            if (phase_cnt_q == PH1_LAST) begin
              state_q <= ASI_ST_PH2;
              phase_cnt_q <= 23'h000000;
              hpf_sel_q <= highpass_select_i;
            end else begin
              phase_cnt_q <= phase_cnt_q + 23'h000001;
            end
          end
          ASI_ST_PH2: begin
            if (phase_cnt_q == (hpf_sel_q ? PH2_HPF_LAST : PH2_LAST)) begin
              state_q <= ASI_ST_DONE;
              phase_cnt_q <= 23'h000000;
            end else begin
              phase_cnt_q <= phase_cnt_q + 23'h000001;
            end
          end
          ASI_ST_DONE: begin
            state_q <= ASI_ST_DONE;
          end
          default: begin
            state_q <= ASI_ST_RESET;
          end
        endcase
      end
    end
  end

  wire in_ph1 = (state_q == ASI_ST_PH1) | (state_q == ASI_ST_RESET);
  wire in_ph2 = state_q == ASI_ST_PH2;
  wire init_done = state_q == ASI_ST_DONE;

  // fuse copy: address out, data back one cycle later into the mirror
  logic [FAW:0] fuse_idx_q;
  logic [FAW-1:0] fuse_wr_addr_q;
  logic fuse_wr_q;
  logic fuse_power_q;
  logic [FUSE_DW-1:0] mirror_q [FUSE_WORDS];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      fuse_idx_q <= '0;
      fuse_wr_addr_q <= '0;
      fuse_wr_q <= 1'b0;
      fuse_power_q <= 1'b0;
    end else if (clk_en_i) begin
      fuse_wr_q <= 1'b0;
      if (state_q == ASI_ST_RESET) begin
        fuse_idx_q <= '0;
        fuse_power_q <= ~int_rst_q;
      end else if (state_q == ASI_ST_PH1 && fuse_idx_q != FUSE_LAST) begin
        fuse_idx_q <= fuse_idx_q + 1'b1;
        fuse_wr_addr_q <= fuse_idx_q[FAW-1:0];
        fuse_wr_q <= 1'b1;
      end else if (!fuse_wr_q) begin
        fuse_power_q <= 1'b0;
      end
    end
  end

  // mirror registers, written only during the copy
  always_ff @(posedge clk_sys_i) begin
    if (clk_en_i && fuse_wr_q) begin
      mirror_q[fuse_wr_addr_q] <= fuse_data_i;
    end
  end

  logic [FUSE_DW-1:0] mirror_rd_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mirror_rd_q <= '0;
    end else if (clk_en_i) begin
      mirror_rd_q <= init_done ? mirror_q[mirror_addr_i] : '0;
    end
  end

  // frame monitor on the synchronised pins, disabled in phase one
  asi_link_if lk ();

  assign lk.sclk = pin_sync_q[0];
  assign lk.cs_act = ~pin_sync_q[1];
  assign lk.enable = ~in_ph1 & ~int_rst_q;

  asi_frame_mon #(
    .EDGES(`ASI_FRAME_EDGES)
  ) u_frame_mon (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .lk(lk)
  );

  wire acc_frame = lk.frame_end & acc_request_i;

  // per-axis result coding, overflow recovery and output buffer
  asi_code_type code_q [2];
  asi_code_type buf_q [2];

  for (genvar a = 0; a < 2; a++) begin : g_axis
    wire signed [LPF_W-1:0] raw = lpf_data_i[a*LPF_W +: LPF_W];
    wire ovf = raw >= SAT_HI;
    wire unf = raw <= SAT_LO;
    wire signed [LPF_W-1:0] clipped = ovf ? SAT_HI : (unf ? SAT_LO : raw);
    logic [3:0] rec_q;
    logic rec_pos_q;
    asi_code_type code_d;

    // clipped value mapped onto the 10-bit code space
    always_comb begin
      if (ovf || (rec_q != 4'h0 && rec_pos_q)) begin
        code_d = `ASI_CODE_OVERFLOW;
      end else if (unf || rec_q != 4'h0) begin
        code_d = `ASI_CODE_UNDERFLOW;
      end else if (clipped > LIN_HI) begin
        code_d = `ASI_CODE_OVERRANGE;
      end else if (clipped < LIN_LO) begin
        code_d = `ASI_CODE_UNDERRANGE;
      end else begin
        code_d = clipped[9:0];
      end
    end

    // quiet samples after saturation before linear codes
    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || int_rst_q) begin
        rec_q <= 4'h0;
        rec_pos_q <= 1'b0;
        code_q[a] <= `ASI_CODE_RESET;
      end else if (clk_en_i && lpf_valid_i) begin
        if (ovf || unf) begin
          rec_q <= REC_LOAD;
          rec_pos_q <= ovf;
        end else if (rec_q != 4'h0) begin
          rec_q <= rec_q - 4'h1;
        end
        code_q[a] <= code_d;
      end
    end

    // buffer holds while frozen, filter runs on
    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || int_rst_q) begin
        buf_q[a] <= `ASI_CODE_RESET;
      end else if (clk_en_i && !freeze) begin
        buf_q[a] <= code_q[a];
      end
    end
  end

  // transient offset error, clear wins for one cycle
  logic ofs_err_q;
  wire ofs_cond = offset_monitor_enable_i & (offset_monitor_i >= OFS_LIMIT);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || int_rst_q) begin
      ofs_err_q <= 1'b0;
    end else if (clk_en_i) begin
      if (clear_error_i) begin
        ofs_err_q <= 1'b0;
      end else if (ofs_cond) begin
        ofs_err_q <= 1'b1;
      end
    end
  end

  // clock fault held until one acceleration answer carries it
  logic ext_err_q;
  logic reset_seen_q;
  logic first_pend_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || int_rst_q) begin
      ext_err_q <= 1'b0;
    end else if (clk_en_i) begin
      if (lk.fault) begin
        ext_err_q <= 1'b1; // set wins over the report
      end else if (acc_frame && ext_err_q && !first_pend_q && init_done) begin
        ext_err_q <= 1'b0;
      end
    end
  end

  // reset-seen flag and the first-request marker
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reset_seen_q <= 1'b0;
      first_pend_q <= 1'b0;
    end else if (clk_en_i) begin
      if (rst_release) begin
        reset_seen_q <= 1'b1;
      end else if (clear_error_i && init_done) begin
        reset_seen_q <= 1'b0;
      end
      if (rst_release) begin
        first_pend_q <= 1'b1;
      end else if (acc_frame) begin
        first_pend_q <= 1'b0;
      end
    end
  end

  // answer: reset status, then init, then errors
  logic resp_valid_q;
  logic reg_frame_q;
  asi_resp_type resp_kind_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      resp_valid_q <= 1'b0;
      reg_frame_q <= 1'b0;
      resp_kind_q <= ASI_RESP_DATA;
    end else if (clk_en_i) begin
      resp_valid_q <= acc_frame;
      reg_frame_q <= lk.frame_end & ~acc_request_i;
      if (acc_frame) begin
        if (first_pend_q) begin
          resp_kind_q <= ASI_RESP_RESET;
        end else if (in_ph2) begin
          resp_kind_q <= ASI_RESP_NO_DATA;
        end else if (ext_err_q || ofs_err_q || lk.fault) begin
          resp_kind_q <= ASI_RESP_ERROR;
        end else begin
          resp_kind_q <= ASI_RESP_DATA;
        end
      end
    end
  end

  // high-pass init through phase two when selected
  logic hpf_init_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      hpf_init_q <= 1'b0;
    end else if (clk_en_i) begin
      hpf_init_q <= (state_q == ASI_ST_PH1 && phase_cnt_q == PH1_LAST) ? highpass_select_i :
                    (in_ph2 ? hpf_sel_q : 1'b0);
    end
  end

  // status byte, upper bits zero; pending shows as soon as reset enters
  logic [7:0] status_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      status_q <= 8'h02;
    end else if (clk_en_i) begin
      status_q <= 8'h00;
      status_q[`ASI_STAT_RESET_SEEN] <= reset_seen_q;
      status_q[`ASI_STAT_INIT_PEND] <= ~init_done | int_rst_q;
      status_q[`ASI_STAT_OFS_ERR] <= ofs_err_q;
      status_q[`ASI_STAT_SPI_FAULT] <= ext_err_q;
    end
  end

  // outputs
  assign fuse_addr_o = fuse_idx_q[FAW-1:0];
  assign fuse_power_o = fuse_power_q;
  assign mirror_data_o = mirror_rd_q;
  assign int_reset_o = int_rst_q;
  assign normal_mode_o = normal_mode_q;
  assign hpf_init_o = hpf_init_q;
  assign spi_ignore_o = ~lk.enable;
  assign reg_frame_o = reg_frame_q;
  assign resp_valid_o = resp_valid_q;
  assign resp_kind_o = resp_kind_q;
  assign acc_x_o = buf_q[0];
  assign acc_y_o = buf_q[1];
  assign device_status_reg_o = status_q;
  assign init_pending_flag_o = status_q[`ASI_STAT_INIT_PEND];
  assign reset_seen_flag_o = status_q[`ASI_STAT_RESET_SEEN];
endmodule

// [tb/asi_checker.sv]
`timescale 1ns/10ps
module asi_checker #(
  parameter int PH1_CYCLES = 16000,
  parameter int FULL_SCALE = 1023
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [2:0] supply_ok_i,
  input wire logic capture_freeze_input_i,
  input wire logic clear_error_i,
  input wire logic offset_monitor_enable_i,
  input wire logic [9:0] offset_monitor_i,
  input wire logic highpass_select_i,
  input wire logic fuse_power_o,
  input wire logic int_reset_o,
  input wire logic normal_mode_o,
  input wire logic hpf_init_o,
  input wire logic spi_ignore_o,
  input wire logic reg_frame_o,
  input wire logic resp_valid_o,
  input wire asi_pkg::asi_code_type acc_x_o,
  input wire asi_pkg::asi_code_type acc_y_o,
  input wire logic [7:0] device_status_reg_o,
  input wire logic init_pending_flag_o,
  input wire logic reset_seen_flag_o
);
  import asi_pkg::*;
  localparam int OFS_LIM = (FULL_SCALE * 10 + 99) / 100;
  logic [15:0] ign_q;

  // phase one length counter
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || int_reset_o || !spi_ignore_o) begin
      ign_q <= 16'h0;
    end else begin
      ign_q <= ign_q + 16'h1;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // rail low long enough to pass the synchroniser
  sequence s_rail_low;
    supply_ok_i != 3'h7 ##1 supply_ok_i != 3'h7;
  endsequence
  // offset condition held, no clear
  sequence s_ofs_hold;
    (offset_monitor_enable_i && offset_monitor_i >= OFS_LIM && !clear_error_i && !int_reset_o) [*3];
  endsequence

  a_rail_holds_reset: assert property (s_rail_low |-> ##[0:3] int_reset_o)
    else $error("internal reset not raised on low rail");
  a_ignore_no_answer: assert property (spi_ignore_o |-> !resp_valid_o && !reg_frame_o)
    else $error("answer given in phase one");
  a_phase_one_len: assert property ($fell(spi_ignore_o) && !int_reset_o |->
    ign_q >= PH1_CYCLES && ign_q <= PH1_CYCLES + 2)
    else $error("phase one length wrong");
  a_fuse_power_off: assert property (!spi_ignore_o |-> !fuse_power_o)
    else $error("fuse power still on after phase one");
  a_hpf_only_sel: assert property (hpf_init_o |-> !spi_ignore_o && highpass_select_i)
    else $error("high-pass init outside phase two or unselected");
  a_pending_early: assert property (spi_ignore_o ##1 spi_ignore_o |-> init_pending_flag_o)
    else $error("init pending flag low during phase one");
  a_reset_seen_set: assert property ($fell(int_reset_o) |-> ##[1:3] reset_seen_flag_o)
    else $error("reset seen flag not set");
  a_offset_flag: assert property (s_ofs_hold |-> ##[0:1] device_status_reg_o[2])
    else $error("offset error not flagged");
  a_codes_legal: assert property (acc_x_o != 10'h1ff && acc_x_o != 10'h200 &&
    acc_y_o != 10'h1ff && acc_y_o != 10'h200)
    else $error("reserved result code seen");
  a_normal_mode: assert property (normal_mode_o)
    else $error("normal mode not indicated");
  a_freeze_stable: assert property ((capture_freeze_input_i && !int_reset_o) [*4] |=>
    $stable(acc_x_o) && $stable(acc_y_o))
    else $error("buffers changed while frozen");
endmodule

// [tb/asi_host_model.sv]
`timescale 1ns/10ps
module asi_host_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [4:0] edges_i,
  input wire logic hi_sel_i,
  input wire logic [2:0] fuse_addr_i,
  output logic [7:0] fuse_data_o,
  output logic sclk_o,
  output logic cs_n_o,
  output logic busy_o
);
  // fuse words, one cycle latency
  always @(posedge clk_i) fuse_data_o <= 8'h5a ^ {5'h0, fuse_addr_i};

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    busy_o = 1'b0;
  end

  // one frame per go pulse; clock idles low
  always @(posedge go_i) begin
    busy_o = 1'b1;
    #37;
    sclk_o = hi_sel_i; // high at select only when a fault is wanted
    #200;
    cs_n_o = 1'b0;
    #200;
    sclk_o = 1'b0;
    #200;
    repeat (edges_i) begin // edge count chosen by the bench
      sclk_o = 1'b1;
      #200;
      sclk_o = 1'b0;
      #200;
    end
    cs_n_o = 1'b1;
    #400;
    busy_o = 1'b0;
  end
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
  import asi_pkg::*;
  localparam int PH1 = 20;
  localparam int PH2 = 800;
  localparam int PH2H = 1000;
  logic clk_sys_i, rst_n_i, clk_en_i, capture_freeze_input_i, acc_request_i, clear_error_i;
  logic offset_monitor_enable_i, highpass_select_i, lpf_valid_i, go, hisel;
  logic [2:0] supply_ok_i, mirror_addr_i, fuse_addr_o;
  logic [9:0] offset_monitor_i;
  logic [31:0] lpf_data_i;
  logic [7:0] fuse_data_i, mirror_data_o, device_status_reg_o;
  logic [4:0] edges;
  logic sclk_i, cs_n_i, host_busy, fuse_power_o, int_reset_o, normal_mode_o, hpf_init_o;
  logic spi_ignore_o, reg_frame_o, resp_valid_o, init_pending_flag_o, reset_seen_flag_o;
  asi_resp_type resp_kind_o, kind_q;
  asi_code_type acc_x_o, acc_y_o;
  int fail_count, checked, na, nr, cyc, c0;
  int raw_t[17] = '{0, 508, 509, 600, -509, -510, -600, 1023, 0, 0, 0, 0, -1023, 0, 0, 0, 0};
  int exp_t[17] = '{0, 508, 509, 509, -509, -510, -510, 510, 510, 510, 510, 0, -511, -511, -511, -511, 0};

  asi_status_init #(.PH1_CYCLES(PH1), .PH2_CYCLES(PH2), .PH2_HPF_CYCLES(PH2H)) dut_u (
    .clk_sys_i, .rst_n_i, .clk_en_i, .supply_ok_i, .sclk_i, .cs_n_i, .capture_freeze_input_i,
    .acc_request_i, .clear_error_i, .offset_monitor_enable_i, .offset_monitor_i, .highpass_select_i,
    .lpf_valid_i, .lpf_data_i, .fuse_data_i, .mirror_addr_i, .fuse_addr_o, .fuse_power_o,
    .mirror_data_o, .int_reset_o, .normal_mode_o, .hpf_init_o, .spi_ignore_o, .reg_frame_o,
    .resp_valid_o, .resp_kind_o, .acc_x_o, .acc_y_o, .device_status_reg_o, .init_pending_flag_o,
    .reset_seen_flag_o);

  asi_host_model host_u (.clk_i(clk_sys_i), .go_i(go), .edges_i(edges), .hi_sel_i(hisel), .fuse_addr_i(fuse_addr_o),
    .fuse_data_o(fuse_data_i), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .busy_o(host_busy));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // count answers, keep last kind
  always @(negedge clk_sys_i) begin
    cyc++;
    if (resp_valid_o === 1'b1) begin
      na++;
      kind_q = resp_kind_o;
    end
    if (reg_frame_o === 1'b1) nr++;
  end

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic bit pending(input int sel);
    case (sel)
      0: return spi_ignore_o !== 1'b0;
      1: return init_pending_flag_o !== 1'b0;
      3: return host_busy !== 1'b0;
      default: return int_reset_o !== 1'b0;
    endcase
  endfunction

  // bounded wait; timeout fails the run
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while (n < 5000 && pending(sel)) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 5000) begin
      fail_count++;
      close_out();
    end
  endtask

  task automatic frame(input int e, input logic hs, input logic acc);
    @(posedge clk_sys_i);
    acc_request_i <= acc;
    edges <= e[4:0];
    hisel <= hs;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    @(negedge clk_sys_i);
    wait_for(3);
  endtask

  task automatic smp(input int x, input int y);
    @(posedge clk_sys_i);
    lpf_data_i <= {y[15:0], x[15:0]};
    lpf_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    lpf_valid_i <= 1'b0;
    repeat (3) @(negedge clk_sys_i);
  endtask

  task automatic pulse_clear;
    @(posedge clk_sys_i);
    clear_error_i <= 1'b1;
    @(posedge clk_sys_i);
    clear_error_i <= 1'b0;
    repeat (4) @(negedge clk_sys_i);
  endtask

  task automatic set_ofs(input logic en, input int m);
    @(posedge clk_sys_i);
    offset_monitor_enable_i <= en;
    offset_monitor_i <= m[9:0];
    repeat (4) @(negedge clk_sys_i);
  endtask

  // power-up, init, data, errors, re-init
  initial begin
    {rst_n_i, capture_freeze_input_i, acc_request_i, clear_error_i, go, hisel} = 6'h0;
    {offset_monitor_enable_i, highpass_select_i, lpf_valid_i} = 3'h0;
    {offset_monitor_i, lpf_data_i, mirror_addr_i, edges} = '0;
    {fail_count, checked, na, nr, cyc} = '0;
    clk_en_i = 1'b1;
    supply_ok_i = 3'h3;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (10) @(negedge clk_sys_i);
    `CHK(int_reset_o, 1'b1)
    `CHK(init_pending_flag_o, 1'b1)
    @(posedge clk_sys_i);
    supply_ok_i <= 3'h7;
    wait_for(2);
    c0 = cyc;
    frame(16, 1'b0, 1'b1);
    `CHK(na + nr, 0)
    `CHK(fuse_power_o, 1'b0)
    `CHK(hpf_init_o, 1'b0)
    frame(16, 1'b0, 1'b1);
    `CHK(kind_q, ASI_RESP_RESET)
    frame(16, 1'b0, 1'b1);
    `CHK(kind_q, ASI_RESP_NO_DATA)
    frame(16, 1'b0, 1'b0);
    `CHK(nr, 1)
    `CHK(na, 2)
    pulse_clear();
    `CHK(reset_seen_flag_o, 1'b1)
    wait_for(1);
    `CHK(cyc - c0 >= PH1 + PH2 && cyc - c0 <= PH1 + PH2 + 4, 1'b1)
    for (int a = 0; a < 8; a++) begin
      @(posedge clk_sys_i);
      mirror_addr_i <= a[2:0];
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      `CHK(mirror_data_o, 8'h5a ^ {5'h0, a[2:0]})
    end
    pulse_clear();
    `CHK(reset_seen_flag_o, 1'b0)
    for (int i = 0; i < 17; i++) begin
      smp(raw_t[i], raw_t[i]);
      `CHK(acc_x_o, asi_code_type'(exp_t[i]))
      `CHK(acc_y_o, asi_code_type'(exp_t[i]))
    end
    smp(100, -100);
    capture_freeze_input_i <= 1'b1;
    repeat (4) @(negedge clk_sys_i);
    smp(200, -200);
    frame(16, 1'b0, 1'b1);
    `CHK(kind_q, ASI_RESP_DATA)
    `CHK(acc_y_o, asi_code_type'(-100))
    @(posedge clk_sys_i);
    capture_freeze_input_i <= 1'b0;
    repeat (4) @(negedge clk_sys_i);
    `CHK(acc_x_o, asi_code_type'(200))
    set_ofs(1'b0, 1023);
    `CHK(device_status_reg_o[2], 1'b0)
    set_ofs(1'b1, 102);
    `CHK(device_status_reg_o[2], 1'b0)
    set_ofs(1'b1, 103);
    `CHK(device_status_reg_o[2], 1'b1)
    frame(16, 1'b0, 1'b1);
    `CHK(kind_q, ASI_RESP_ERROR)
    pulse_clear();
    `CHK(device_status_reg_o[2], 1'b1)
    set_ofs(1'b1, 0);
    pulse_clear();
    `CHK(device_status_reg_o[2], 1'b0)
    for (int k = 0; k < 3; k++) begin
      frame(k == 0 ? 15 : k == 1 ? 17 : 16, k == 2, 1'b1);
      `CHK(device_status_reg_o[3], 1'b1)
      frame(16, 1'b0, 1'b1);
      `CHK(kind_q, ASI_RESP_ERROR)
      frame(16, 1'b0, 1'b1);
      `CHK(kind_q, ASI_RESP_DATA)
      `CHK(device_status_reg_o[3], 1'b0)
    end
    @(posedge clk_sys_i);
    highpass_select_i <= 1'b1;
    supply_ok_i <= 3'h5;
    repeat (6) @(negedge clk_sys_i);
    `CHK(int_reset_o, 1'b1)
    @(posedge clk_sys_i);
    supply_ok_i <= 3'h7;
    wait_for(2);
    c0 = cyc;
    wait_for(0);
    repeat (3) @(negedge clk_sys_i);
    `CHK(hpf_init_o, 1'b1)
    `CHK(reset_seen_flag_o, 1'b1)
    wait_for(1);
    `CHK(cyc - c0 >= PH1 + PH2H && cyc - c0 <= PH1 + PH2H + 4, 1'b1)
    close_out();
  end
endmodule

bind asi_status_init asi_checker #(.PH1_CYCLES(PH1_CYCLES), .FULL_SCALE(FULL_SCALE)) chk_u (
  .clk_sys_i, .rst_n_i, .supply_ok_i, .capture_freeze_input_i, .clear_error_i,
  .offset_monitor_enable_i, .offset_monitor_i, .highpass_select_i, .fuse_power_o, .int_reset_o,
  .normal_mode_o, .hpf_init_o, .spi_ignore_o, .reg_frame_o, .resp_valid_o, .acc_x_o, .acc_y_o,
  .device_status_reg_o, .init_pending_flag_o, .reset_seen_flag_o);
